// ===== syndrome0_pkg.sv
// Constants and types shared by the error record syndrome register 0 block
package syndrome0_pkg;
	localparam logic [15:0] BASE_OFFSET   = 16'h0020;
	localparam int          RECORD_STRIDE = 64;
	localparam int          REG_BITS      = 64;
	localparam int          HALF_BITS     = 32;
	localparam int          WIDE_COUNT    = 15;
	localparam int          NARROW_COUNT  = 7;
	localparam int          A_LSB         = 32;
	localparam int          A16_OF        = 47;
	localparam int          A8_OF         = 39;
	localparam int          B16_LSB       = 48;
	localparam int          B16_OF        = 63;
	localparam int          B8_LSB        = 40;
	localparam int          B8_OF         = 47;
	localparam int          ARMED_BIT     = 31;
	localparam int          CAPTURE_BITS  = 31;
	localparam logic [2:0]  FEAT_NONE     = 3'h0;
	localparam logic [2:0]  FEAT_COUNT8   = 3'h2;
	localparam logic [2:0]  FEAT_COUNT16  = 3'h4;
	localparam logic [1:0]  HALF_WHOLE    = 2'h0;
	localparam logic [1:0]  HALF_LOW      = 2'h1;
	localparam logic [1:0]  HALF_HIGH     = 2'h2;
	localparam logic [63:0] LOW_MASK      = 64'h0000_0000_FFFF_FFFF;
	localparam logic [63:0] HIGH_MASK     = 64'hFFFF_FFFF_0000_0000;

	typedef enum logic [2:0] {
		LAYOUT_IMPL     = 3'h0,
		LAYOUT_SINGLE8  = 3'h1,
		LAYOUT_SINGLE16 = 3'h3,
		LAYOUT_PAIR8    = 3'h2,
		LAYOUT_PAIR16   = 3'h6
	} layout_e;
endpackage

// ===== wrap_counter.sv
// Error counter with narrow or wide wrap point and sticky overflow flag
`timescale 1ns/1ps
module wrap_counter #(
	parameter int WIDTH  = 15,
	parameter int NARROW = 7
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	input  wire logic             i_narrow,
	input  wire logic             i_inc,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_load_count,
	input  wire logic             i_load_overflow,
	output logic      [WIDTH-1:0] o_count,
	output logic                  o_overflow,
	output logic                  o_wrapped
);
	logic [WIDTH-1:0] count;
	logic             overflow;
	logic [WIDTH-1:0] next_count;
	logic             next_overflow;
	logic             wraps;
	logic [WIDTH-1:0] narrow_mask;

	generate
		if (NARROW >= WIDTH || NARROW < 1) begin : g_bad
			$error("wrap_counter: NARROW must be below WIDTH");
		end
	endgenerate

	always_comb begin
		narrow_mask = {WIDTH{1'b1}} >> (WIDTH - NARROW);
		wraps = i_narrow ? ((count & narrow_mask) == narrow_mask) : (&count);
		next_count = count;
		next_overflow = overflow;
		o_wrapped = 1'b0;
		if (i_load) begin
			// A software write beats a same-cycle increment
			next_count = i_narrow ? (i_load_count & narrow_mask) : i_load_count; // R23
			next_overflow = i_load_overflow; // R19
		end else if (i_inc) begin
			next_count = wraps ? '0 : WIDTH'(count + 1'b1); // R7
			if (wraps) begin
				next_overflow = 1'b1; // R7
				o_wrapped = 1'b1;
			end
		end
	end

	// Of the two resets only cold reset clears the counters; recovery reset never reaches here
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count <= '0; // R9
			overflow <= 1'b0;
		end else begin
			count <= next_count;
			overflow <= next_overflow;
		end
	end

	assign o_count = count;
	assign o_overflow = overflow;
endmodule // wrap_counter

// ===== access_merge.sv
// Merges memory-mapped and selected-record accesses into one write strobe and mask
`timescale 1ns/1ps
module access_merge (
	input  wire logic        i_mm_hit,
	input  wire logic        i_mm_write,
	input  wire logic [63:0] i_mm_wdata,
	input  wire logic        i_sys_hit,
	input  wire logic        i_sys_write,
	input  wire logic [1:0]  i_sys_half,
	input  wire logic [63:0] i_sys_wdata,
	output logic             o_wr_en,
	output logic      [63:0] o_wr_data,
	output logic      [63:0] o_wr_mask
);
	always_comb begin
		o_wr_en = 1'b0;
		o_wr_data = '0;
		o_wr_mask = '0;
		// Memory-mapped write wins if both arrive together
		if (i_mm_hit && i_mm_write) begin
			o_wr_en = 1'b1;
			o_wr_data = i_mm_wdata;
			o_wr_mask = '1;
		end else if (i_sys_hit && i_sys_write) begin
			o_wr_en = 1'b1;
			case (i_sys_half) // R17
				syndrome0_pkg::HALF_LOW: begin
					o_wr_data = {32'h0000_0000, i_sys_wdata[31:0]};
					o_wr_mask = syndrome0_pkg::LOW_MASK;
				end
				syndrome0_pkg::HALF_HIGH: begin
					o_wr_data = {i_sys_wdata[31:0], 32'h0000_0000};
					o_wr_mask = syndrome0_pkg::HIGH_MASK;
				end
				default: begin
					o_wr_data = i_sys_wdata;
					o_wr_mask = '1;
				end
			endcase
		end
	end
endmodule // access_merge

// ===== error_record_syndrome0.sv
// Syndrome register 0 of one error record with standard corrected error counters
//
// Function
// R1 - Writing zero returns record to initial state
// R2 - Zero write withdraws syndrome interrupt request
// R3 - Memory view at 0x020 plus 64 per record
// R4 - Counter layout only when feature nonzero, countable
// R5 - Single 16-bit: overflow 47, count 46:32
// R6 - Single 8-bit: overflow 39, count 38:32
// R7 - Count each corrected error; wrap sets sticky overflow
// R8 - Deferred, uncorrected error counting is our choice
// R9 - Counters kept across error recovery reset
// R10 - Overflow writes may disturb record overflow flag
// R11 - Pair 16-bit: 63, 62:48, 47, 46:32
// R12 - Pair 8-bit: 47, 46:40, 39, 38:32
// R13 - Repeat counts first error and matching syndrome
// R14 - Other counts errors not counted as repeat
// R15 - Non-counter bits are implementation defined
// R16 - Absent record reads zero, ignores writes
// R17 - Selected-record view, whole or 32-bit halves
// R18 - Syndrome interrupts disabled at cold reset
// R19 - Counters are writable by software
// R20 - Latest syndrome ignores writes while valid; here a zero write still clears it
// R21 - Feature code selects 8-bit or 16-bit counters
// R22 - Repeat-present flag selects pair layout
// R23 - Same-cycle write beats counter increment
`timescale 1ns/1ps
module error_record_syndrome0 #(
	parameter int RECORD_INDEX   = 0,
	parameter bit RECORD_PRESENT = 1'b1,
	parameter bit COUNTABLE      = 1'b1,
	parameter int ADDR_W         = 16,
	parameter int INDEX_W        = 8
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	input  wire logic               i_err_recovery_reset,
	input  wire logic [2:0]         i_feature_counter,
	input  wire logic               i_repeat_counter_present,
	input  wire logic               i_irq_enable,
	input  wire logic               i_syndrome_valid_flag,
	input  wire logic               i_corrected_error,
	input  wire logic [30:0]        i_other_syndrome,
	input  wire logic               i_mm_valid,
	input  wire logic               i_mm_write,
	input  wire logic [ADDR_W-1:0]  i_mm_addr,
	input  wire logic [63:0]        i_mm_wdata,
	input  wire logic               i_index_write,
	input  wire logic [INDEX_W-1:0] i_index_wdata,
	input  wire logic               i_sys_valid,
	input  wire logic               i_sys_write,
	input  wire logic [1:0]         i_sys_half,
	input  wire logic [63:0]        i_sys_wdata,
	output logic                    o_mm_ack,
	output logic      [63:0]        o_mm_rdata,
	output logic                    o_sys_ack,
	output logic      [63:0]        o_sys_rdata,
	output logic      [INDEX_W-1:0] o_record_choice_index,
	output logic                    o_fault_irq,
	output logic                    o_overflow_event
);
	localparam logic [ADDR_W-1:0] MY_ADDR =
		ADDR_W'(syndrome0_pkg::BASE_OFFSET) + ADDR_W'(syndrome0_pkg::RECORD_STRIDE * RECORD_INDEX);

	generate
		if (RECORD_INDEX < 0 || RECORD_INDEX >= (1 << INDEX_W)) begin : g_bad_index
			$error("error_record_syndrome0: RECORD_INDEX out of range");
		end
		if ((syndrome0_pkg::RECORD_STRIDE * (RECORD_INDEX + 1)) >= (1 << ADDR_W)) begin : g_bad_addr
			$error("error_record_syndrome0: ADDR_W too small for RECORD_INDEX");
		end
	endgenerate

	syndrome0_pkg::layout_e layout;
	logic        counting;
	logic        pair;
	logic        narrow;
	logic        mm_hit;
	logic        sys_hit;
	logic        wr_en;
	logic [63:0] wr_data;
	logic [63:0] wr_mask;
	logic [63:0] read_word;
	logic [63:0] merged;
	logic        wr_upper;
	logic        wr_lower;
	logic        countable;
	logic        match;
	logic        inc_a;
	logic        inc_b;
	logic [14:0] a_cnt;
	logic [14:0] b_cnt;
	logic        a_of;
	logic        b_of;
	logic        a_wrapped;
	logic        b_wrapped;
	logic [14:0] a_load_cnt;
	logic [14:0] b_load_cnt;
	logic        a_load_of;
	logic        b_load_of;

	logic [30:0]        captured;
	logic               armed;
	logic [INDEX_W-1:0] choice_index;
	logic               mm_ack;
	logic [63:0]        mm_rdata;
	logic               sys_ack;
	logic [63:0]        sys_rdata;
	logic               fault_irq;
	logic               overflow_event;

	logic [30:0]        next_captured;
	logic               next_armed;
	logic [INDEX_W-1:0] next_choice_index;
	logic               next_mm_ack;
	logic [63:0]        next_mm_rdata;
	logic               next_sys_ack;
	logic [63:0]        next_sys_rdata;
	logic               next_fault_irq;
	logic               next_overflow_event;

	// Layout decode; reserved feature codes fall back to plain syndrome
	always_comb begin
		layout = syndrome0_pkg::LAYOUT_IMPL;
		if (COUNTABLE) begin // R4
			case (i_feature_counter) // R21
				syndrome0_pkg::FEAT_COUNT8: layout = i_repeat_counter_present ?
					syndrome0_pkg::LAYOUT_PAIR8 : syndrome0_pkg::LAYOUT_SINGLE8; // R22
				syndrome0_pkg::FEAT_COUNT16: layout = i_repeat_counter_present ?
					syndrome0_pkg::LAYOUT_PAIR16 : syndrome0_pkg::LAYOUT_SINGLE16; // R22
				default: layout = syndrome0_pkg::LAYOUT_IMPL;
			endcase
		end
		counting = (layout != syndrome0_pkg::LAYOUT_IMPL);
		pair = (layout == syndrome0_pkg::LAYOUT_PAIR8) || (layout == syndrome0_pkg::LAYOUT_PAIR16);
		narrow = (layout == syndrome0_pkg::LAYOUT_SINGLE8) || (layout == syndrome0_pkg::LAYOUT_PAIR8);
	end

	// Address and selection decode
	always_comb begin
		mm_hit = i_mm_valid && (i_mm_addr == MY_ADDR); // R3
		sys_hit = i_sys_valid && (choice_index == INDEX_W'(RECORD_INDEX)); // R17
	end

	access_merge u_merge (
		.i_mm_hit    (mm_hit),
		.i_mm_write  (i_mm_write),
		.i_mm_wdata  (i_mm_wdata),
		.i_sys_hit   (sys_hit),
		.i_sys_write (i_sys_write),
		.i_sys_half  (i_sys_half),
		.i_sys_wdata (i_sys_wdata),
		.o_wr_en     (wr_en),
		.o_wr_data   (wr_data),
		.o_wr_mask   (wr_mask)
	);

	// Read assembly and write field extraction
	always_comb begin
		read_word = '0;
		read_word[syndrome0_pkg::ARMED_BIT] = armed; // R15
		read_word[syndrome0_pkg::CAPTURE_BITS-1:0] = captured;
		case (layout)
			syndrome0_pkg::LAYOUT_SINGLE16: begin
				read_word[syndrome0_pkg::A16_OF] = a_of; // R5
				read_word[syndrome0_pkg::A_LSB +: 15] = a_cnt;
			end
			syndrome0_pkg::LAYOUT_SINGLE8: begin
				read_word[syndrome0_pkg::A8_OF] = a_of; // R6
				read_word[syndrome0_pkg::A_LSB +: 7] = a_cnt[6:0];
			end
			syndrome0_pkg::LAYOUT_PAIR16: begin
				read_word[syndrome0_pkg::B16_OF] = b_of; // R11
				read_word[syndrome0_pkg::B16_LSB +: 15] = b_cnt;
				read_word[syndrome0_pkg::A16_OF] = a_of;
				read_word[syndrome0_pkg::A_LSB +: 15] = a_cnt;
			end
			syndrome0_pkg::LAYOUT_PAIR8: begin
				read_word[syndrome0_pkg::B8_OF] = b_of; // R12
				read_word[syndrome0_pkg::B8_LSB +: 7] = b_cnt[6:0];
				read_word[syndrome0_pkg::A8_OF] = a_of;
				read_word[syndrome0_pkg::A_LSB +: 7] = a_cnt[6:0];
			end
			default: read_word[63:32] = 32'h0000_0000;
		endcase
		if (!RECORD_PRESENT) begin
			read_word = '0; // R16
		end
		merged = (read_word & ~wr_mask) | (wr_data & wr_mask);
		wr_upper = wr_en && RECORD_PRESENT && counting && (|wr_mask[63:32]); // R19
		wr_lower = wr_en && RECORD_PRESENT && (|wr_mask[31:0]);
		a_load_cnt = narrow ? {8'h00, merged[syndrome0_pkg::A_LSB +: 7]}
			: merged[syndrome0_pkg::A_LSB +: 15];
		a_load_of = narrow ? merged[syndrome0_pkg::A8_OF] : merged[syndrome0_pkg::A16_OF];
		b_load_cnt = narrow ? {8'h00, merged[syndrome0_pkg::B8_LSB +: 7]}
			: merged[syndrome0_pkg::B16_LSB +: 15];
		b_load_of = narrow ? merged[syndrome0_pkg::B8_OF] : merged[syndrome0_pkg::B16_OF];
	end

	// Only corrected errors are counted; deferred and uncorrected never are
	always_comb begin
		countable = i_corrected_error && counting && RECORD_PRESENT; // R8
		match = armed && (i_other_syndrome == captured);
		inc_a = countable && (!pair || !armed || match); // R13
		inc_b = countable && pair && armed && !match; // R14
	end

	wrap_counter #(
		.WIDTH  (syndrome0_pkg::WIDE_COUNT),
		.NARROW (syndrome0_pkg::NARROW_COUNT)
	) u_repeat (
		.i_clock         (i_clock),
		.i_rst           (i_rst),
		.i_narrow        (narrow),
		.i_inc           (inc_a),
		.i_load          (wr_upper),
		.i_load_count    (a_load_cnt),
		.i_load_overflow (a_load_of),
		.o_count         (a_cnt),
		.o_overflow      (a_of),
		.o_wrapped       (a_wrapped)
	);

	wrap_counter #(
		.WIDTH  (syndrome0_pkg::WIDE_COUNT),
		.NARROW (syndrome0_pkg::NARROW_COUNT)
	) u_other (
		.i_clock         (i_clock),
		.i_rst           (i_rst),
		.i_narrow        (narrow),
		.i_inc           (inc_b),
		.i_load          (wr_upper && pair),
		.i_load_count    (b_load_cnt),
		.i_load_overflow (b_load_of),
		.o_count         (b_cnt),
		.o_overflow      (b_of),
		.o_wrapped       (b_wrapped)
	);

	// Syndrome, selection and answer state
	always_comb begin
		next_captured = captured;
		next_armed = armed;
		next_choice_index = choice_index;
		if (i_index_write) begin
			next_choice_index = i_index_wdata; // R17
		end
		if (i_err_recovery_reset) begin
			next_captured = '0;
			next_armed = 1'b0;
		end else if (wr_lower) begin
			// Zero always lands; other values are dropped, not held, while the syndrome valid flag is set
			if (merged[31:0] == 32'h0000_0000) begin
				next_captured = '0; // R1
				next_armed = 1'b0;
			end else if (!i_syndrome_valid_flag) begin // R20
				next_captured = merged[syndrome0_pkg::CAPTURE_BITS-1:0];
				next_armed = merged[syndrome0_pkg::ARMED_BIT];
			end
		end else if (countable && !armed) begin
			next_captured = i_other_syndrome; // R13
			next_armed = 1'b1;
		end
		next_mm_ack = mm_hit;
		next_mm_rdata = (mm_hit && !i_mm_write) ? read_word : '0;
		next_sys_ack = sys_hit;
		next_sys_rdata = '0;
		if (sys_hit && !i_sys_write) begin
			case (i_sys_half)
				syndrome0_pkg::HALF_LOW: next_sys_rdata = {32'h0000_0000, read_word[31:0]};
				syndrome0_pkg::HALF_HIGH: next_sys_rdata = {32'h0000_0000, read_word[63:32]};
				default: next_sys_rdata = read_word;
			endcase
		end
		next_fault_irq = i_irq_enable && (a_of || (pair && b_of)); // R2 R18
		next_overflow_event = a_wrapped || b_wrapped; // R10
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			captured <= '0;
			armed <= 1'b0;
			choice_index <= '0;
			mm_ack <= 1'b0;
			mm_rdata <= '0;
			sys_ack <= 1'b0;
			sys_rdata <= '0;
			fault_irq <= 1'b0;
			overflow_event <= 1'b0;
		end else begin
			captured <= next_captured;
			armed <= next_armed;
			choice_index <= next_choice_index;
			mm_ack <= next_mm_ack;
			mm_rdata <= next_mm_rdata;
			sys_ack <= next_sys_ack;
			sys_rdata <= next_sys_rdata;
			fault_irq <= next_fault_irq;
			overflow_event <= next_overflow_event;
		end
	end

	assign o_mm_ack = mm_ack;
	assign o_mm_rdata = mm_rdata;
	assign o_sys_ack = sys_ack;
	assign o_sys_rdata = sys_rdata;
	assign o_record_choice_index = choice_index;
	assign o_fault_irq = fault_irq;
	assign o_overflow_event = overflow_event;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_zero_clears: assert property (wr_lower && !i_err_recovery_reset && merged[31:0] == '0 // R1
		|=> !armed && captured == '0) else $error("zero write left syndrome set");
	a_irq_withdraw: assert property (wr_en && wr_mask == '1 && wr_data == '0 // R2
		&& counting && RECORD_PRESENT ##1 !wr_en |=> !o_fault_irq)
		else $error("interrupt not withdrawn after zero write");
	a_mm_answer: assert property (o_mm_ack == $past(mm_hit)) // R3
		else $error("memory access answer mistimed");
	a_single16_inc: assert property (layout == syndrome0_pkg::LAYOUT_SINGLE16 && countable // R5
		&& !wr_upper && a_cnt != 15'h7FFF |=> a_cnt == $past(a_cnt) + 15'h0001)
		else $error("wide counter missed an error");
	a_narrow_wrap: assert property (layout == syndrome0_pkg::LAYOUT_SINGLE8 && countable // R6
		&& !wr_upper && a_cnt[6:0] == 7'h7F |=> a_cnt == 15'h0000 && a_of && o_overflow_event
		##1 !o_overflow_event) else $error("narrow counter wrap mishandled");
	a_overflow_sticky: assert property (a_of && !wr_upper |=> a_of) // R7
		else $error("overflow flag dropped without a write");
	a_other_count: assert property (countable && pair && armed && !match && !wr_upper // R14
		&& b_cnt[6:0] != 7'h7F |=> b_cnt != $past(b_cnt) && $stable(a_cnt))
		else $error("mismatching error not counted as other");
	a_write_wins: assert property (wr_upper && countable |=> a_cnt == $past(a_load_cnt) // R23
		&& a_of == $past(a_load_of)) else $error("increment beat a software write");
	a_recovery_keeps: assert property (i_err_recovery_reset && !wr_upper && !countable // R9
		|=> $stable(a_cnt) && $stable(a_of) && !armed)
		else $error("recovery reset disturbed counters");
	a_absent_zero: assert property (!RECORD_PRESENT |-> o_mm_rdata == '0 && o_sys_rdata == '0) // R16
		else $error("absent record returned data");
	a_valid_locks: assert property (wr_lower && i_syndrome_valid_flag && !i_err_recovery_reset // R20
		&& merged[31:0] != '0 && armed |=> $stable(captured))
		else $error("syndrome overwritten while valid");

	c_overflow: cover property (o_overflow_event);
	c_repeat_then_other: cover property (inc_a && pair ##[1:20] inc_b);
	c_irq_cleared: cover property (o_fault_irq ##[1:10] !o_fault_irq);
	c_half_write: cover property (sys_hit && i_sys_write && i_sys_half == syndrome0_pkg::HALF_HIGH);
endmodule // error_record_syndrome0

// ===== tb.sv
// Self-checking testbench for the error record syndrome register 0 block
`timescale 1ns/1ps
module tb;
	logic        i_clock, i_rst, i_err_recovery_reset, i_repeat_counter_present;
	logic        i_irq_enable, i_syndrome_valid_flag, i_corrected_error;
	logic        i_mm_valid, i_mm_write, i_index_write, i_sys_valid, i_sys_write;
	logic [2:0]  i_feature_counter;
	logic [30:0] i_other_syndrome;
	logic [15:0] i_mm_addr;
	logic [63:0] i_mm_wdata, i_sys_wdata, o_mm_rdata, o_sys_rdata;
	logic [7:0]  i_index_wdata, o_record_choice_index;
	logic [1:0]  i_sys_half;
	logic        o_mm_ack, o_sys_ack, o_fault_irq, o_overflow_event;
	int          miscompares;
	int          tests_run;

	localparam logic [63:0] HI   = syndrome0_pkg::HIGH_MASK;
	localparam logic [30:0] SYN_A = 31'h0000_1234;
	localparam logic [30:0] SYN_B = 31'h0000_0055;

	error_record_syndrome0 error_record_syndrome0_inst (.*);

	initial begin
		i_clock = 1'b0;
	end
	always #25 i_clock = ~i_clock;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Request held for one edge; the answer is sampled at the following falling edge
	task automatic mm(input logic wr, input logic [15:0] addr, input logic [63:0] wd,
			input logic hit, output logic [63:0] rd);
		@(negedge i_clock);
		i_mm_valid = 1'b1;
		i_mm_write = wr;
		i_mm_addr = addr;
		i_mm_wdata = wd;
		@(negedge i_clock);
		i_mm_valid = 1'b0;
		i_mm_write = 1'b0;
		check({63'h0, o_mm_ack}, {63'h0, hit});
		rd = o_mm_rdata;
	endtask

	task automatic wr(input logic [63:0] wd);
		logic [63:0] d;
		mm(1'b1, 16'h0020, wd, 1'b1, d);
	endtask

	task automatic rd(output logic [63:0] d);
		mm(1'b0, 16'h0020, 64'h0, 1'b1, d);
	endtask

	task automatic sys(input logic w, input logic [1:0] half, input logic [63:0] wd,
			input logic hit, output logic [63:0] d);
		@(negedge i_clock);
		i_sys_valid = 1'b1;
		i_sys_write = w;
		i_sys_half = half;
		i_sys_wdata = wd;
		@(negedge i_clock);
		i_sys_valid = 1'b0;
		i_sys_write = 1'b0;
		check({63'h0, o_sys_ack}, {63'h0, hit});
		d = o_sys_rdata;
	endtask

	task automatic set_index(input logic [7:0] idx);
		@(negedge i_clock);
		i_index_write = 1'b1;
		i_index_wdata = idx;
		@(negedge i_clock);
		i_index_write = 1'b0;
		check({56'h0, o_record_choice_index}, {56'h0, idx});
	endtask

	task automatic err(input logic [30:0] syn);
		@(negedge i_clock);
		i_corrected_error = 1'b1;
		i_other_syndrome = syn;
		@(negedge i_clock);
		i_corrected_error = 1'b0;
	endtask

	task automatic t_layout_none();
		logic [63:0] d;
		rd(d);
		check(d, 64'h0);
		mm(1'b0, 16'h0060, 64'h0, 1'b0, d);
		mm(1'b0, 16'h0028, 64'h0, 1'b0, d);
		i_feature_counter = 3'h3;
		wr(64'h0000_1234_0000_0000);
		rd(d);
		check(d & HI, 64'h0);
	endtask

	task automatic t_single16();
		logic [63:0] d;
		i_feature_counter = 3'h4;
		i_repeat_counter_present = 1'b0;
		i_irq_enable = 1'b1;
		wr(64'h0000_7FFE_0000_0000);
		err(SYN_A);
		rd(d);
		check(d & HI, 64'h0000_7FFF_0000_0000);
		err(SYN_A);
		check({63'h0, o_overflow_event}, 64'h1);
		check({63'h0, o_fault_irq}, 64'h0);
		@(negedge i_clock);
		check({63'h0, o_overflow_event}, 64'h0);
		check({63'h0, o_fault_irq}, 64'h1);
		rd(d);
		check(d & HI, 64'h0000_8000_0000_0000);
		err(SYN_B);
		rd(d);
		check(d & HI, 64'h0000_8001_0000_0000);
		wr(64'h0);
		@(negedge i_clock);
		check({63'h0, o_fault_irq}, 64'h0);
		rd(d);
		check(d, 64'h0);
	endtask

	task automatic t_single8();
		logic [63:0] d;
		i_feature_counter = 3'h2;
		i_irq_enable = 1'b0;
		wr(64'hFFFF_FF7F_0000_0000);
		rd(d);
		check(d & HI, 64'h0000_007F_0000_0000);
		err(SYN_A);
		@(negedge i_clock);
		check({63'h0, o_fault_irq}, 64'h0);
		i_irq_enable = 1'b1;
		@(negedge i_clock);
		check({63'h0, o_fault_irq}, 64'h1);
		rd(d);
		check(d & HI, 64'h0000_0080_0000_0000);
	endtask

	task automatic t_pair16();
		logic [63:0] d;
		i_feature_counter = 3'h4;
		i_repeat_counter_present = 1'b1;
		wr(64'h0);
		err(SYN_A);
		err(SYN_A);
		err(SYN_B);
		rd(d);
		check(d, 64'h0001_0002_8000_1234);
		i_syndrome_valid_flag = 1'b1;
		wr(64'h0004_0003_8000_0077);
		rd(d);
		check(d, 64'h0004_0003_8000_1234);
		i_syndrome_valid_flag = 1'b0;
		@(negedge i_clock);
		i_err_recovery_reset = 1'b1;
		@(negedge i_clock);
		i_err_recovery_reset = 1'b0;
		rd(d);
		check(d, 64'h0004_0003_0000_0000);
		err(SYN_B);
		rd(d);
		check(d, 64'h0004_0004_8000_0055);
		@(negedge i_clock);
		i_mm_valid = 1'b1;
		i_mm_write = 1'b1;
		i_mm_addr = 16'h0020;
		i_mm_wdata = 64'h0;
		i_corrected_error = 1'b1;
		@(negedge i_clock);
		i_mm_valid = 1'b0;
		i_mm_write = 1'b0;
		i_corrected_error = 1'b0;
		rd(d);
		check(d, 64'h0);
	endtask

	task automatic t_pair8();
		logic [63:0] d;
		i_feature_counter = 3'h2;
		err(SYN_A);
		err(SYN_B);
		err(SYN_B);
		rd(d);
		check(d, 64'h0000_0201_8000_1234);
		wr(64'h0000_7F00_0000_0000);
		err(SYN_A);
		err(SYN_B);
		rd(d);
		check(d, 64'h0000_8001_8000_1234);
	endtask

	task automatic t_sys_view();
		logic [63:0] d;
		set_index(8'h00);
		sys(1'b1, 2'h2, 64'h0000_0000_0000_0005, 1'b1, d);
		sys(1'b0, 2'h1, 64'h0, 1'b1, d);
		check(d & 64'h0000_0000_FFFF_FFFF, 64'h0000_0000_8000_1234);
		sys(1'b0, 2'h2, 64'h0, 1'b1, d);
		check(d & 64'h0000_0000_FFFF_FFFF, 64'h0000_0000_0000_0005);
		sys(1'b1, 2'h1, 64'h0, 1'b1, d);
		sys(1'b0, 2'h0, 64'h0, 1'b1, d);
		check(d, 64'h0000_0005_0000_0000);
		set_index(8'h01);
		sys(1'b0, 2'h0, 64'h0, 1'b0, d);
		set_index(8'h00);
	endtask

	initial begin
		miscompares = 0;
		tests_run = 0;
		i_rst = 1'b1;
		i_err_recovery_reset = 1'b0;
		i_feature_counter = 3'h0;
		i_repeat_counter_present = 1'b0;
		i_irq_enable = 1'b0;
		i_syndrome_valid_flag = 1'b0;
		i_corrected_error = 1'b0;
		i_other_syndrome = 31'h0;
		i_mm_valid = 1'b0;
		i_mm_write = 1'b0;
		i_mm_addr = 16'h0;
		i_mm_wdata = 64'h0;
		i_index_write = 1'b0;
		i_index_wdata = 8'h0;
		i_sys_valid = 1'b0;
		i_sys_write = 1'b0;
		i_sys_half = 2'h0;
		i_sys_wdata = 64'h0;
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
		i_rst = 1'b0;
		t_layout_none();
		t_single16();
		t_single8();
		t_pair16();
		t_pair8();
		t_sys_view();
		test_done();
	end
endmodule // tb
